// File: logic/burst_port_pkg.sv
package burst_port_pkg;

  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int LANES = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // Address map, byte addresses.
  localparam logic [ADDR_W-1:0] MAP_END = 16'h1000;
  localparam int CH_LSB = 10;
  localparam logic [9:0] HOLD_OFS = 10'h000;
  localparam logic [9:0] FIFO_OFS = 10'h100;
  localparam logic [9:0] STAT_OFS = 10'h200;
  localparam logic [9:0] STAT_END = 10'h3FF;

  // Line status word fields.
  localparam int LSW_DATA_BIT = 0;
  localparam int LSW_TXEMPTY_BIT = 6;

  // Transmit staging buffer.
  localparam int TXQ_DEPTH = 16;
  localparam int TXQ_W = CH_W + LANES + DATA_W;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_HOLD = 3'b001,
    K_FIFO = 3'b010,
    K_STAT = 3'b011,
    K_BAD = 3'b100
  } win_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WPUSH = 3'b001,
    S_RLANE = 3'b010,
    S_RWAIT = 3'b011,
    S_RESP = 3'b100
  } port_state_t;

endpackage

// File: logic/stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: logic/sync_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Streams.
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  assign in_s.ready = (q.cnt != FULL_CNT);
  assign out_s.valid = (q.cnt != '0);
  assign out_s.data = mem[q.rd];
  assign do_wr = in_s.valid && in_s.ready;
  assign do_rd = out_s.valid && out_s.ready;

  always_comb begin
    d = q;
    if (do_wr) begin
      d.wr = (q.wr == LAST_PTR) ? '0 : q.wr + 1'b1;
    end
    if (do_rd) begin
      d.rd = (q.rd == LAST_PTR) ? '0 : q.rd + 1'b1;
    end
    if (do_wr && !do_rd) begin
      d.cnt = q.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem[q.wr] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// File: logic/tx_drain.sv
`timescale 1ns/100ps
`default_nettype none
module tx_drain
  import burst_port_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Staged words.
  stream_if.snk word_s,
  // Transmit FIFO side.
  input wire logic [NUM_CH-1:0] tx_space_i,
  output logic [NUM_CH-1:0] tx_push_o,
  output logic [BYTE_W-1:0] tx_byte_o
);
  typedef struct packed {
    logic busy;
    logic gap;
    logic [1:0] lane;
    logic [TXQ_W-1:0] word;
    logic [NUM_CH-1:0] push;
    logic [BYTE_W-1:0] byte_v;
  } drain_state_t;

  drain_state_t q, d;
  logic [CH_W-1:0] ch;
  logic [LANES-1:0] be;
  logic [DATA_W-1:0] dat;

  assign word_s.ready = !q.busy;
  assign ch = q.word[TXQ_W-1 -: CH_W];
  assign be = q.word[DATA_W +: LANES];
  assign dat = q.word[DATA_W-1:0];
  assign tx_push_o = q.push;
  assign tx_byte_o = q.byte_v;

  always_comb begin
    d = q;
    d.push = '0;
    d.gap = 1'b0;
    if (!q.busy) begin
      if (word_s.valid) begin
        d.busy = 1'b1;
        d.word = word_s.data;
        d.lane = 2'h0;
      end
    end else if (!q.gap) begin
      if (!be[q.lane] || tx_space_i[ch]) begin
        if (be[q.lane]) begin
          d.push[ch] = 1'b1;
          d.byte_v = dat[q.lane*BYTE_W +: BYTE_W];
          d.gap = 1'b1;
        end
        if (q.lane == 2'h3) begin
          d.busy = 1'b0;
        end else begin
          d.lane = q.lane + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: logic/uart_fifo_burst_data_port.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - The channel FIFO window moves one byte per enabled lane, 8 to 32 bits.
// - The status window returns each received byte beside its status word.
// - Bursts of up to 256 bytes run as back-to-back beats; writes stall while the 16-entry staging buffer is full.
// - The legacy holding ports move only byte lane 0, one byte per access.
// - Any mapped address takes burst beats; reserved space reads as zero.
// - Channel N decodes its FIFO window at 0x(4N+1)00 to 0x(4N+1)FF.
// - Each channel has a 512-byte status window right after its FIFO window.
// - FIFO window reads unload bytes with the oldest in the lowest lane.
// - Legacy receive holding ports sit at 0x000, 0x400, 0x800 and 0xC00.
// - Status window pairs put status in the lower lane, data above it.
// - FIFO window writes load bytes with the lowest lane first.
// - Status bit 0 shows data present and bit 6 a fully empty transmitter.
module uart_fifo_burst_data_port
  import burst_port_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Bus request.
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [LANES-1:0] req_be_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  // Bus response.
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic rsp_err_o,
  // Receive FIFO side.
  input wire logic [NUM_CH-1:0] rx_avail_i,
  input wire logic [NUM_CH-1:0][BYTE_W-1:0] rx_byte_i,
  input wire logic [NUM_CH-1:0][BYTE_W-1:0] rx_flags_i,
  input wire logic [NUM_CH-1:0] tx_empty_i,
  output logic [NUM_CH-1:0] rx_pop_o,
  // Transmit FIFO side.
  input wire logic [NUM_CH-1:0] tx_space_i,
  output logic [NUM_CH-1:0] tx_push_o,
  output logic [BYTE_W-1:0] tx_byte_o
);
  typedef struct packed {
    port_state_t st;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
    logic err;
    logic [CH_W-1:0] ch;
    logic [LANES-1:0] be;
    win_kind_t kind;
    logic [1:0] lane;
    logic [NUM_CH-1:0] pop;
    logic txq_valid;
    logic [TXQ_W-1:0] txq_data;
  } port_q_t;

  port_q_t q, d;
  win_kind_t req_kind;
  logic [NUM_CH-1:0][BYTE_W-1:0] lsw;
  logic lane_on;
  logic lane_last;
  logic [1:0] lane_step;

  stream_if #(.WIDTH(TXQ_W)) txq_in ();
  stream_if #(.WIDTH(TXQ_W)) txq_out ();

  assign txq_in.valid = q.txq_valid;
  assign txq_in.data = q.txq_data;

  assign req_ready_o = q.ready;
  assign rsp_valid_o = q.rsp_valid;
  assign rsp_rdata_o = q.rdata;
  assign rsp_err_o = q.err;
  assign rx_pop_o = q.pop;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_lsw
      always_comb begin
        lsw[gi] = rx_flags_i[gi];
        lsw[gi][LSW_DATA_BIT] = rx_avail_i[gi];
        lsw[gi][LSW_TXEMPTY_BIT] = tx_empty_i[gi];
      end
    end
  endgenerate

  // Window decode of the request address.
  always_comb begin
    req_kind = K_NONE;
    if (req_addr_i >= MAP_END) begin
      req_kind = K_BAD;
    end else if (req_addr_i[9:0] >= FIFO_OFS &&
                 req_addr_i[9:0] < STAT_OFS) begin
      req_kind = K_FIFO;
    end else if (req_addr_i[9:0] >= STAT_OFS &&
                 req_addr_i[9:0] <= STAT_END) begin
      req_kind = K_STAT;
    end else if (req_addr_i[9:2] == HOLD_OFS[9:2]) begin
      req_kind = K_HOLD;
    end
  end

  // Whether the current lane is serviced, and where the next one is.
  always_comb begin
    lane_on = 1'b0;
    lane_step = 2'h1;
    case (q.kind)
      K_FIFO: begin
        lane_on = q.be[q.lane];
      end
      K_HOLD: begin
        lane_on = (q.lane == 2'h0) && q.be[0];
      end
      K_STAT: begin
        lane_on = q.be[q.lane] || q.be[q.lane + 2'h1];
        lane_step = 2'h2;
      end
      default: begin
        lane_on = 1'b0;
      end
    endcase
    lane_last = (q.lane == 2'h3) || (q.kind == K_STAT && q.lane == 2'h2);
  end

  always_comb begin
    d = q;
    d.pop = '0;
    d.rsp_valid = 1'b0;
    case (q.st)
      S_IDLE: begin
        d.ready = 1'b1;
        if (req_valid_i && q.ready) begin
          d.ready = 1'b0;
          d.ch = req_addr_i[CH_LSB +: CH_W];
          d.be = req_be_i;
          d.kind = req_kind;
          d.lane = 2'h0;
          d.rdata = '0;
          d.err = 1'b0;
          if (req_kind == K_BAD) begin
            d.err = 1'b1;
            d.rsp_valid = 1'b1;
            d.st = S_RESP;
          end else if (req_write_i) begin
            if (req_kind == K_FIFO && req_be_i != '0) begin
              d.txq_valid = 1'b1;
              d.txq_data = {req_addr_i[CH_LSB +: CH_W], req_be_i,
                            req_wdata_i};
              d.st = S_WPUSH;
            end else if (req_kind == K_HOLD && req_be_i[0]) begin
              d.txq_valid = 1'b1;
              d.txq_data = {req_addr_i[CH_LSB +: CH_W], 4'h1,
                            req_wdata_i};
              d.st = S_WPUSH;
            end else begin
              d.rsp_valid = 1'b1;
              d.st = S_RESP;
            end
          end else if (req_kind == K_NONE) begin
            d.rsp_valid = 1'b1;
            d.st = S_RESP;
          end else begin
            d.st = S_RLANE;
          end
        end
      end
      S_WPUSH: begin
        if (txq_in.ready) begin
          d.txq_valid = 1'b0;
          d.rsp_valid = 1'b1;
          d.st = S_RESP;
        end
      end
      S_RLANE: begin
        if (lane_on && rx_avail_i[q.ch]) begin
          d.pop[q.ch] = 1'b1;
          if (q.kind == K_STAT) begin
            d.rdata[q.lane*BYTE_W +: BYTE_W] = lsw[q.ch];
            d.rdata[(q.lane+2'h1)*BYTE_W +: BYTE_W] = rx_byte_i[q.ch];
          end else begin
            d.rdata[q.lane*BYTE_W +: BYTE_W] = rx_byte_i[q.ch];
          end
          d.st = S_RWAIT;
        end else begin
          if (lane_on && q.kind == K_STAT) begin
            d.rdata[q.lane*BYTE_W +: BYTE_W] = lsw[q.ch];
          end
          if (lane_last) begin
            d.rsp_valid = 1'b1;
            d.st = S_RESP;
          end else begin
            d.lane = q.lane + lane_step;
          end
        end
      end
      S_RWAIT: begin
        if (lane_last) begin
          d.rsp_valid = 1'b1;
          d.st = S_RESP;
        end else begin
          d.lane = q.lane + lane_step;
          d.st = S_RLANE;
        end
      end
      S_RESP: begin
        d.ready = 1'b1;
        d.st = S_IDLE;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  sync_fifo #(
    .WIDTH(TXQ_W),
    .DEPTH(TXQ_DEPTH)
  ) u_txq (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_s(txq_in),
    .out_s(txq_out)
  );

  tx_drain u_drain (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .word_s(txq_out),
    .tx_space_i(tx_space_i),
    .tx_push_o(tx_push_o),
    .tx_byte_o(tx_byte_o)
  );
endmodule
`default_nettype wire

// File: tb/burst_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module burst_port_assertions
  import burst_port_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Bus side.
  input wire logic req_valid_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic rsp_err_o,
  // FIFO side.
  input wire logic [NUM_CH-1:0] rx_avail_i,
  input wire logic [NUM_CH-1:0] rx_pop_o,
  input wire logic [NUM_CH-1:0] tx_space_i,
  input wire logic [NUM_CH-1:0] tx_push_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence take_s;
    req_valid_i && req_ready_o;
  endsequence
  sequence beat_end_s;
    rsp_valid_o ##1 req_ready_o;
  endsequence
  a_take_busy: assert property (take_s |=> !req_ready_o)
    else $error("ready high after a take");
  a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response longer than one cycle");
  a_ready_return: assert property (rsp_valid_o |-> beat_end_s)
    else $error("ready not back after response");
  a_err_unmapped: assert property (take_s ##0 (req_addr_i >= MAP_END)
    |-> ##[1:2] (rsp_valid_o && rsp_err_o))
    else $error("unmapped beat without error");
  a_pop_avail: assert property ((rx_pop_o != '0)
    |-> (rx_pop_o & ~$past(rx_avail_i)) == '0)
    else $error("pop from empty receive FIFO");
  a_pop_in_beat: assert property ((rx_pop_o != '0)
    |-> $onehot(rx_pop_o) && !req_ready_o)
    else $error("pop outside a single channel beat");
  a_pop_gap: assert property ((rx_pop_o != '0) |=> rx_pop_o == '0)
    else $error("pops back to back");
  a_push_space: assert property ((tx_push_o != '0)
    |-> (tx_push_o & ~$past(tx_space_i)) == '0)
    else $error("push into full transmit FIFO");
  a_push_gap: assert property ((tx_push_o != '0) |=> tx_push_o == '0)
    else $error("pushes back to back");
endmodule
`default_nettype wire

// File: tb/uart_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module uart_side_model
  import burst_port_pkg::*;
(
  // Clock and stall control.
  input wire logic clock_i,
  input wire logic stall_i,
  // Design side.
  input wire logic [NUM_CH-1:0] rx_pop_i,
  input wire logic [NUM_CH-1:0] tx_push_i,
  input wire logic [BYTE_W-1:0] tx_byte_i,
  output logic [NUM_CH-1:0] rx_avail_o,
  output logic [NUM_CH-1:0][BYTE_W-1:0] rx_byte_o,
  output logic [NUM_CH-1:0][BYTE_W-1:0] rx_flags_o,
  output logic [NUM_CH-1:0] tx_empty_o,
  output logic [NUM_CH-1:0] tx_space_o
);
  logic [BYTE_W-1:0] rxq[NUM_CH][$];
  logic [BYTE_W-1:0] txq[NUM_CH][$];
  task automatic load(input int c, input logic [BYTE_W-1:0] b);
    rxq[c].push_back(b);
  endtask
  always @(posedge clock_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rx_pop_i[c] && rxq[c].size() > 0) begin
        void'(rxq[c].pop_front());
      end
      if (tx_push_i[c]) begin
        txq[c].push_back(tx_byte_i);
      end
      rx_avail_o[c] <= rxq[c].size() > 0;
      if (rxq[c].size() > 0) begin
        rx_byte_o[c] <= rxq[c][0];
        rx_flags_o[c] <= rxq[c][0] ^ 8'h3C;
      end else begin
        rx_byte_o[c] <= ~rx_byte_o[c];
        rx_flags_o[c] <= ~rx_flags_o[c];
      end
      tx_empty_o[c] <= txq[c].size() == 0;
      tx_space_o[c] <= !stall_i;
    end
  end
endmodule
`default_nettype wire

// File: tb/uart_fifo_burst_data_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module uart_fifo_burst_data_port_bench
  import burst_port_pkg::*;
;
  typedef struct {
    logic w;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] wd;
    logic cr;
    logic [DATA_W-1:0] exp;
    logic err;
  } row_t;
  logic clock_i, rst_i, req_valid_i, req_write_i, req_ready_o;
  logic rsp_valid_o, rsp_err_o, er, stall;
  logic [ADDR_W-1:0] req_addr_i;
  logic [LANES-1:0] req_be_i;
  logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, rd;
  logic [NUM_CH-1:0] rx_avail_i, tx_empty_i, rx_pop_o, tx_space_i, tx_push_o;
  logic [NUM_CH-1:0][BYTE_W-1:0] rx_byte_i, rx_flags_i;
  logic [BYTE_W-1:0] tx_byte_o;
  row_t rows[11];
  int failures, n_checks, n;
  uart_fifo_burst_data_port i_dut (.clock_i, .rst_i, .req_valid_i,
    .req_write_i, .req_addr_i, .req_be_i, .req_wdata_i, .req_ready_o,
    .rsp_valid_o, .rsp_rdata_o, .rsp_err_o, .rx_avail_i, .rx_byte_i,
    .rx_flags_i, .tx_empty_i, .rx_pop_o, .tx_space_i, .tx_push_o, .tx_byte_o);
  uart_side_model i_far (.clock_i, .stall_i(stall), .rx_pop_i(rx_pop_o),
    .tx_push_i(tx_push_o), .tx_byte_i(tx_byte_o), .rx_avail_o(rx_avail_i),
    .rx_byte_o(rx_byte_i), .rx_flags_o(rx_flags_i), .tx_empty_o(tx_empty_i),
    .tx_space_o(tx_space_i));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    end_of_test();
  end
  function automatic logic [7:0] st(input logic [7:0] b);
    st = (b ^ 8'h3C) | 8'h41;
  endfunction
  task automatic end_of_test();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic beat(input logic w, input logic [15:0] a,
    input logic [3:0] be, input logic [31:0] wd);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_be_i <= be;
    req_wdata_i <= wd;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (!req_ready_o && n < 1000);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (!rsp_valid_o && n < 1000);
    rd = rsp_rdata_o;
    er = rsp_err_o;
    if (n >= 1000) begin
      failures++;
    end
  endtask
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 16'h0000;
    req_be_i = 4'h0;
    req_wdata_i = 32'h0;
    stall = 1'b0;
    for (int k = 0; k < 256; k++) begin
      i_far.load(0, 8'(k));
      if (k < 5) i_far.load(1, 8'(8'h11 * (k + 1)));
      if (k < 3) i_far.load(2, 8'(8'hA1 + k));
      if (k < 2) i_far.load(3, 8'(8'hC1 + k));
    end
    repeat (12) @(posedge clock_i);
    check("ready_rst", 32'h0, 32'(req_ready_o));
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check("ready_idle", 32'h1, 32'(req_ready_o));
    rows = '{
      '{1'b0, 16'h0500, 4'hF, 32'h0, 1'b1, 32'h44332211, 1'b0},
      '{1'b0, 16'h0500, 4'h1, 32'h0, 1'b1, 32'h00000055, 1'b0},
      '{1'b0, 16'h0500, 4'hF, 32'h0, 1'b1, 32'h00000000, 1'b0},
      '{1'b0, 16'h0A00, 4'hF, 32'h0, 1'b1,
        {8'hA2, st(8'hA2), 8'hA1, st(8'hA1)}, 1'b0},
      '{1'b0, 16'h0B00, 4'h3, 32'h0, 1'b1, {16'h0, 8'hA3, st(8'hA3)}, 1'b0},
      // Holding read returns channel 3's oldest byte; the status reads before it were on channel 2.
      '{1'b0, 16'h0C00, 4'hF, 32'h0, 1'b1, 32'h000000C1, 1'b0},
      '{1'b0, 16'h1000, 4'hF, 32'h0, 1'b0, 32'h0, 1'b1},
      '{1'b1, 16'h0100, 4'hF, 32'h04030201, 1'b0, 32'h0, 1'b0},
      '{1'b1, 16'h0000, 4'hF, 32'h00000077, 1'b0, 32'h0, 1'b0},
      '{1'b1, 16'h0D00, 4'h3, 32'h0000BBAA, 1'b0, 32'h0, 1'b0},
      '{1'b1, 16'h0A00, 4'hF, 32'h12345678, 1'b0, 32'h0, 1'b0}};
    foreach (rows[i]) begin
      beat(rows[i].w, rows[i].a, rows[i].be, rows[i].wd);
      if (rows[i].cr) check("rdata", rows[i].exp, rd);
      check("err", 32'(rows[i].err), 32'(er));
    end
    for (int k = 0; k < 256; k += 4) begin
      beat(1'b0, 16'h0100 + 16'(k), 4'hF, 32'h0);
      check("burst_rd", {8'(k + 3), 8'(k + 2), 8'(k + 1), 8'(k)}, rd);
    end
    stall <= 1'b1;
    fork
      begin
        repeat (400) @(posedge clock_i);
        stall <= 1'b0;
      end
      for (int k = 0; k < 256; k += 4) begin
        beat(1'b1, 16'h0500 + 16'(k), 4'hF,
          {8'(k + 3), 8'(k + 2), 8'(k + 1), 8'(k)});
      end
    join
    n = 0;
    while (i_far.txq[1].size() < 256 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    for (int j = 0; j < 256; j++) begin
      check("tx_burst", 32'(j), 32'(i_far.txq[1][j]));
    end
    check("tx_word", 32'h04030201, {i_far.txq[0][3], i_far.txq[0][2],
      i_far.txq[0][1], i_far.txq[0][0]});
    check("tx_hold", 32'h77, 32'(i_far.txq[0][4]));
    check("tx_half", 32'hBBAA, {i_far.txq[3][1], i_far.txq[3][0]});
    check("tx_sizes", 32'h05000200, {8'(i_far.txq[0].size()),
      8'(i_far.txq[2].size()), 8'(i_far.txq[3].size()), 8'h0});
    end_of_test();
  end
endmodule
bind uart_fifo_burst_data_port burst_port_assertions i_chk (.clock_i,
  .rst_i, .req_valid_i, .req_addr_i, .req_ready_o, .rsp_valid_o, .rsp_err_o,
  .rx_avail_i, .rx_pop_o, .tx_space_i, .tx_push_o);
`default_nettype wire
